/* File: hdl/ppfm_pkg.sv */
package ppfm_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_CFG       = 8'h00;
    localparam logic [7:0] OFS_GPIO_CFG  = 8'h04;
    localparam logic [7:0] OFS_WAKE_EN   = 8'h08;
    localparam logic [7:0] OFS_SMI_EN    = 8'h0C;
    localparam logic [7:0] OFS_INT_STAT  = 8'h10;
    localparam logic [7:0] OFS_INT_MASK  = 8'h14;
    localparam logic [7:0] OFS_PP_DATA   = 8'h18;
    localparam logic [7:0] OFS_PP_CTRL   = 8'h1C;
    localparam logic [7:0] OFS_PP_STAT   = 8'h20;
    localparam logic [7:0] OFS_OWNER     = 8'h24;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CFG_POWER      = 0;
    localparam int CFG_MODE_LO    = 1;
    localparam int CFG_MODE_HI    = 2;
    localparam int CFG_FIELD_LSB  = 4;
    localparam int GPIO_FUNC      = 0;
    localparam int GPIO_POL       = 1;
    localparam int GPIO_DIR_IN    = 3;
    localparam int WAKE_EN_BIT    = 5;
    localparam int SMI_EN_BIT     = 4;
    localparam int INT_SW_EDGE    = 0;
    localparam int INT_OWNER_CHG  = 1;

    // Control pins: strobe, autofeed, init, select-in
    localparam int CTL_STB = 0;
    localparam int CTL_AFD = 1;
    localparam int CTL_INI = 2;
    localparam int CTL_SLI = 3;
    // Status pins: ack, busy, paper end, selected, error
    localparam int ST_ACK  = 0;
    localparam int ST_BSY  = 1;
    localparam int ST_PEND = 2;
    localparam int ST_SELD = 3;
    localparam int ST_ERR  = 4;
    // Floppy controller output order
    localparam int FD_DS0  = 0;
    localparam int FD_DS1  = 1;
    localparam int FD_MT0  = 2;
    localparam int FD_MT1  = 3;
    localparam int FD_WDA  = 4;
    localparam int FD_WGT  = 5;
    localparam int FD_DEN  = 6;
    localparam int FD_HDS  = 7;
    localparam int FD_DIR  = 8;
    localparam int FD_STP  = 9;

    // ************************************************************
    // Reset and forced values, switch field codes
    // ************************************************************
    localparam logic [31:0] RST_WORD      = 32'h0000_0000;
    localparam logic [3:0]  CTRL_NO_CABLE = 4'h4;
    localparam logic [4:0]  STAT_FORCED   = 5'h09;
    localparam logic [1:0]  FIELD_OFF     = 2'h0;
    localparam logic [1:0]  FIELD_A       = 2'h1;
    localparam logic [1:0]  FIELD_B       = 2'h2;

endpackage

/* File: hdl/ppfm_top.sv */
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

module ppfm_top (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             irq_o,
    input  wire logic        shared_gpio_pin_i,
    output logic             wake_evt_o,
    output logic             smi_evt_o,
    input  wire logic [9:0]  fdc_sig_i,
    input  wire logic        fdc_port_sel_i,
    output logic      [4:0]  fdc_rd_o,
    input  wire logic [4:0]  fdd_in_i,
    output logic      [9:0]  fdd_out_o,
    output logic      [9:0]  fdd_oe_o,
    input  wire logic [7:0]  conn_data_i,
    output logic      [7:0]  conn_data_o,
    output logic      [7:0]  conn_data_oe_o,
    input  wire logic [3:0]  conn_ctl_i,
    output logic      [3:0]  conn_ctl_o,
    output logic      [3:0]  conn_ctl_oe_o,
    input  wire logic [4:0]  conn_stat_i,
    output logic      [4:0]  conn_stat_o,
    output logic      [4:0]  conn_stat_oe_o,
    input  wire logic        pp_irq_i,
    input  wire logic        pp_smi_i,
    input  wire logic        pp_drq_i,
    output logic             pp_irq_o,
    output logic             pp_smi_o,
    output logic             pp_drq_o,
    output logic             pp_enable_o
);
    import ppfm_pkg::*;

    // ************************************************************
    // Registers and synchroniser
    // ************************************************************
    logic [7:0] cfg_reg;
    logic [3:0] gpio_cfg_reg;
    logic [7:0] wake_en_reg;
    logic [7:0] smi_en_reg;
    logic [1:0] int_stat_reg;
    logic [1:0] int_mask_reg;
    logic [7:0] pp_data_reg;
    logic [5:0] pp_ctrl_reg;
    logic       sw_meta_reg;
    logic       sw_sync_reg;
    logic       sw_prev_reg;
    logic       owns_prev_reg;

    // ************************************************************
    // Ownership decode
    // ************************************************************
    wire  [1:0] field      = cfg_reg[CFG_FIELD_LSB +: 2];
    wire        mode_lo    = cfg_reg[CFG_MODE_LO];
    wire        mode_hi    = cfg_reg[CFG_MODE_HI];
    wire        floppy_cfg = mode_lo | mode_hi;
    wire        dual       = mode_hi;
    wire        sw_armed   = gpio_cfg_reg[GPIO_FUNC] & gpio_cfg_reg[GPIO_DIR_IN];
    wire        sw_used    = sw_armed & ((field == FIELD_A) | (field == FIELD_B));
    wire        sw_floppy  = ~(sw_sync_reg ^ gpio_cfg_reg[GPIO_POL]);
    wire        floppy_owns = floppy_cfg & (~sw_used | sw_floppy);
    wire        pp_on      = cfg_reg[CFG_POWER] & ~floppy_owns;
    wire        native_off = floppy_owns & fdc_port_sel_i;
    wire        sw_edge    = sw_sync_reg ^ sw_prev_reg;
    wire        wake_ev    = sw_edge & sw_armed & wake_en_reg[WAKE_EN_BIT];
    wire        smi_ev     = sw_edge & sw_armed & smi_en_reg[SMI_EN_BIT];

    // ************************************************************
    // Pin mux next values
    // ************************************************************
    logic [7:0] data_o_next;
    logic [7:0] data_oe_next;
    logic [3:0] ctl_o_next;
    logic [3:0] ctl_oe_next;
    logic [4:0] stat_o_next;
    logic [4:0] stat_oe_next;

    always_comb begin
        data_o_next  = pp_data_reg;
        data_oe_next = {8{pp_on & ~pp_ctrl_reg[5]}};
        ctl_o_next   = pp_ctrl_reg[3:0];
        ctl_oe_next  = {4{pp_on}};
        stat_o_next  = 5'h00;
        stat_oe_next = 5'h00;
        if (floppy_owns) begin
            data_o_next           = 8'h00;
            data_oe_next          = 8'h00;
            data_o_next[6]        = fdc_sig_i[FD_MT0];
            data_oe_next[6]       = dual;
            ctl_o_next[CTL_STB]   = fdc_sig_i[FD_DS0];
            ctl_oe_next[CTL_STB]  = dual;
            ctl_o_next[CTL_AFD]   = fdc_sig_i[FD_DEN];
            ctl_o_next[CTL_INI]   = fdc_sig_i[FD_DIR];
            ctl_o_next[CTL_SLI]   = fdc_sig_i[FD_STP];
            ctl_oe_next[CTL_AFD]  = 1'b1;
            ctl_oe_next[CTL_INI]  = 1'b1;
            ctl_oe_next[CTL_SLI]  = 1'b1;
            stat_o_next[ST_ACK]   = fdc_sig_i[FD_DS1];
            stat_o_next[ST_BSY]   = fdc_sig_i[FD_MT1];
            stat_o_next[ST_PEND]  = fdc_sig_i[FD_WDA];
            stat_o_next[ST_SELD]  = fdc_sig_i[FD_WGT];
            stat_o_next[ST_ERR]   = fdc_sig_i[FD_HDS];
            stat_oe_next          = 5'h1F;
        end
    end

    wire [4:0] fdc_rd_next = floppy_owns ? conn_data_i[4:0] : fdd_in_i;

    // ************************************************************
    // APB decode
    // ************************************************************
    wire        acc      = psel_i & penable_i & ~pready_o;
    wire        wr       = acc & pwrite_i;
    wire        hit_cfg  = (paddr_i == OFS_CFG);
    wire        hit_gpio = (paddr_i == OFS_GPIO_CFG);
    wire        hit_wake = (paddr_i == OFS_WAKE_EN);
    wire        hit_smi  = (paddr_i == OFS_SMI_EN);
    wire        hit_ist  = (paddr_i == OFS_INT_STAT);
    wire        hit_imsk = (paddr_i == OFS_INT_MASK);
    wire        hit_dat  = (paddr_i == OFS_PP_DATA);
    wire        hit_ctl  = (paddr_i == OFS_PP_CTRL);
    wire        hit_sts  = (paddr_i == OFS_PP_STAT);
    wire        hit_own  = (paddr_i == OFS_OWNER);
    wire        mapped   = hit_cfg | hit_gpio | hit_wake | hit_smi | hit_ist | hit_imsk
                         | hit_dat | hit_ctl | hit_sts | hit_own;
    wire [7:0]  ctl_rd   = floppy_owns ? {4'h0, CTRL_NO_CABLE}
                                       : {2'b00, pp_ctrl_reg};
    wire [7:0]  sts_rd   = floppy_owns ? {STAT_FORCED, 3'b000}
                                       : {~conn_stat_i[ST_BSY], conn_stat_i[ST_ACK],
                                          conn_stat_i[ST_PEND], conn_stat_i[ST_SELD],
                                          conn_stat_i[ST_ERR], 3'b000};
    wire [7:0]  dat_rd   = floppy_owns ? pp_data_reg : conn_data_i;
    logic [31:0] rd_next;

    always_comb begin
        rd_next = RST_WORD;
        if (hit_cfg) begin
            rd_next[7:0] = cfg_reg;
        end else if (hit_gpio) begin
            rd_next[3:0] = gpio_cfg_reg;
        end else if (hit_wake) begin
            rd_next[7:0] = wake_en_reg;
        end else if (hit_smi) begin
            rd_next[7:0] = smi_en_reg;
        end else if (hit_ist) begin
            rd_next[1:0] = int_stat_reg;
        end else if (hit_imsk) begin
            rd_next[1:0] = int_mask_reg;
        end else if (hit_dat) begin
            rd_next[7:0] = dat_rd;
        end else if (hit_ctl) begin
            rd_next[7:0] = ctl_rd;
        end else if (hit_sts) begin
            rd_next[7:0] = sts_rd;
        end else if (hit_own) begin
            rd_next[2:0] = {sw_sync_reg, pp_on, floppy_owns};
        end
    end

    wire [1:0] ev_set    = {floppy_owns ^ owns_prev_reg, sw_edge & sw_armed};
    wire [1:0] ev_clr    = (wr & hit_ist) ? pwdata_i[1:0] : 2'b00;
    wire [1:0] ist_next  = ev_set | (int_stat_reg & ~ev_clr);

    // ************************************************************
    // Bus registers
    // ************************************************************
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= RST_WORD;
        end else begin
            pready_o  <= acc;
            pslverr_o <= acc & ~mapped;
            prdata_o  <= (acc & ~pwrite_i) ? rd_next : RST_WORD;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_reg      <= 8'h00;
            gpio_cfg_reg <= 4'h0;
            wake_en_reg  <= 8'h00;
            smi_en_reg   <= 8'h00;
            int_mask_reg <= 2'h0;
            pp_data_reg  <= 8'h00;
            pp_ctrl_reg  <= 6'h00;
        end else begin
            if (wr & hit_cfg)  cfg_reg      <= pwdata_i[7:0];
            if (wr & hit_gpio) gpio_cfg_reg <= pwdata_i[3:0];
            if (wr & hit_wake) wake_en_reg  <= pwdata_i[7:0];
            if (wr & hit_smi)  smi_en_reg   <= pwdata_i[7:0];
            if (wr & hit_imsk) int_mask_reg <= pwdata_i[1:0];
            if (wr & hit_dat)  pp_data_reg  <= pwdata_i[7:0];
            if (wr & hit_ctl)  pp_ctrl_reg  <= pwdata_i[5:0];
        end
    end

    // ************************************************************
    // Switch sync, events, interrupt
    // ************************************************************
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sw_meta_reg   <= 1'b1;
            sw_sync_reg   <= 1'b1;
            sw_prev_reg   <= 1'b1;
            owns_prev_reg <= 1'b0;
            int_stat_reg  <= 2'h0;
            irq_o         <= 1'b0;
            wake_evt_o    <= 1'b0;
            smi_evt_o     <= 1'b0;
        end else begin
            sw_meta_reg   <= shared_gpio_pin_i;
            sw_sync_reg   <= sw_meta_reg;
            sw_prev_reg   <= sw_sync_reg;
            owns_prev_reg <= floppy_owns;
            int_stat_reg  <= ist_next;
            irq_o         <= |(ist_next & int_mask_reg);
            wake_evt_o    <= wake_ev;
            smi_evt_o     <= smi_ev;
        end
    end

    // ************************************************************
    // Pin and gating outputs
    // ************************************************************
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            conn_data_o    <= 8'h00;
            conn_data_oe_o <= 8'h00;
            conn_ctl_o     <= 4'h0;
            conn_ctl_oe_o  <= 4'h0;
            conn_stat_o    <= 5'h00;
            conn_stat_oe_o <= 5'h00;
            fdd_out_o      <= 10'h000;
            fdd_oe_o       <= 10'h000;
            fdc_rd_o       <= 5'h1F;
            pp_irq_o       <= 1'b0;
            pp_smi_o       <= 1'b0;
            pp_drq_o       <= 1'b0;
            pp_enable_o    <= 1'b0;
        end else begin
            conn_data_o    <= data_o_next;
            conn_data_oe_o <= data_oe_next;
            conn_ctl_o     <= ctl_o_next;
            conn_ctl_oe_o  <= ctl_oe_next;
            conn_stat_o    <= stat_o_next;
            conn_stat_oe_o <= stat_oe_next;
            fdd_out_o      <= fdc_sig_i;
            fdd_oe_o       <= {10{~native_off}};
            fdc_rd_o       <= fdc_rd_next;
            pp_irq_o       <= pp_irq_i & ~floppy_owns;
            pp_smi_o       <= pp_smi_i & ~floppy_owns;
            pp_drq_o       <= pp_drq_i & ~floppy_owns;
            pp_enable_o    <= pp_on;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    AST_DATA_READBACK: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (pready_o && !pwrite_i && paddr_i == OFS_PP_DATA && $past(floppy_owns))
        |-> prdata_o[7:0] == $past(pp_data_reg))
        else $error("data readback differs from last write");

    AST_CTRL_NO_CABLE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (pready_o && !pwrite_i && paddr_i == OFS_PP_CTRL && $past(floppy_owns))
        |-> prdata_o[7:0] == 8'h04)
        else $error("control read not cable-absent");

    AST_STAT_FORCED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (pready_o && !pwrite_i && paddr_i == OFS_PP_STAT && $past(floppy_owns))
        |-> prdata_o[7:0] == 8'h48)
        else $error("status read not forced");

    AST_NATIVE_TRI: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $past(native_off) |-> fdd_oe_o == 10'h000)
        else $error("native floppy pins driven");

    AST_PORT_OFF: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $past(floppy_owns) || !$past(cfg_reg[CFG_POWER]) |-> !pp_enable_o && conn_ctl_oe_o[CTL_SLI] == $past(floppy_owns))
        else $error("port enabled while off");

    AST_DATA_INPUTS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $past(floppy_owns) |-> (conn_data_oe_o & 8'hBF) == 8'h00)
        else $error("floppy input line driven");

    AST_ACK_DS1: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $past(floppy_owns) |-> conn_stat_o[ST_ACK] == $past(fdc_sig_i[FD_DS1])
            && conn_ctl_o[CTL_SLI] == $past(fdc_sig_i[FD_STP]))
        else $error("floppy output map wrong");

    AST_SINGLE_INPUTS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $past(floppy_owns) |-> conn_ctl_oe_o[CTL_STB] == $past(dual)
            && conn_data_oe_o[6] == $past(dual))
        else $error("drive-0 pins wrong for mode");

    AST_SW_EVENT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (sw_sync_reg != sw_prev_reg && sw_armed && wake_en_reg[WAKE_EN_BIT]) |=> wake_evt_o)
        else $error("switch edge lost");

    AST_FIELD_OFF: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (field == FIELD_OFF && floppy_cfg) |-> floppy_owns)
        else $error("switch acted with field off");

    AST_IRQ_BLOCK: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $past(floppy_owns) |-> !pp_irq_o && !pp_smi_o && !pp_drq_o)
        else $error("port request escaped");

    AST_SYNC_DEPTH: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $past(!rst_i, 2) |-> sw_sync_reg == $past(shared_gpio_pin_i, 2))
        else $error("switch sync depth wrong");

endmodule

/* File: tb/ppfm_floppy_model.sv */
`timescale 1ns/1ps

module ppfm_floppy_model (
    input  wire logic [4:0] media_i,
    input  wire logic [7:0] dev_data_i,
    input  wire logic [7:0] dev_data_oe_i,
    input  wire logic [3:0] dev_ctl_i,
    input  wire logic [3:0] dev_ctl_oe_i,
    input  wire logic [4:0] dev_stat_i,
    input  wire logic [4:0] dev_stat_oe_i,
    output logic      [7:0] pin_data_o,
    output logic      [3:0] pin_ctl_o,
    output logic      [4:0] pin_stat_o
);
    // ************************************************************
    // Drive on data 0-4, pull-ups elsewhere
    // ************************************************************
    wire logic [7:0] drive_data = {3'h7, media_i};
    assign pin_data_o = (dev_data_oe_i & dev_data_i) | (~dev_data_oe_i & drive_data);
    assign pin_ctl_o  = (dev_ctl_oe_i & dev_ctl_i) | ~dev_ctl_oe_i;
    assign pin_stat_o = (dev_stat_oe_i & dev_stat_i) | ~dev_stat_oe_i;
endmodule

/* File: tb/ppfm_top_bench.sv */
`timescale 1ns/1ps

module ppfm_top_bench;
    import ppfm_pkg::*;
    logic        clk, rst, psel, penable, pwrite, pin, port_sel;
    logic        irq_in, smi_in, drq_in;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, irq, wake, smi;
    logic [9:0]  fs, fdd_out, fdd_oe;
    logic [4:0]  media, fdd_in, fdc_rd, st_i, st_o, st_oe;
    logic [7:0]  d_i, d_o, d_oe;
    logic [3:0]  c_i, c_o, c_oe;
    logic        pp_irq, pp_smi, pp_drq, pp_en;
    int          err_count, checks_done;

    ppfm_top ppfm_top_i (
        .sys_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq),
        .shared_gpio_pin_i(pin), .wake_evt_o(wake), .smi_evt_o(smi),
        .fdc_sig_i(fs), .fdc_port_sel_i(port_sel), .fdc_rd_o(fdc_rd),
        .fdd_in_i(fdd_in), .fdd_out_o(fdd_out), .fdd_oe_o(fdd_oe),
        .conn_data_i(d_i), .conn_data_o(d_o), .conn_data_oe_o(d_oe),
        .conn_ctl_i(c_i), .conn_ctl_o(c_o), .conn_ctl_oe_o(c_oe),
        .conn_stat_i(st_i), .conn_stat_o(st_o), .conn_stat_oe_o(st_oe),
        .pp_irq_i(irq_in), .pp_smi_i(smi_in), .pp_drq_i(drq_in), .pp_irq_o(pp_irq),
        .pp_smi_o(pp_smi), .pp_drq_o(pp_drq), .pp_enable_o(pp_en));

    ppfm_floppy_model ppfm_floppy_model_i (
        .media_i(media), .dev_data_i(d_o), .dev_data_oe_i(d_oe), .dev_ctl_i(c_o),
        .dev_ctl_oe_i(c_oe), .dev_stat_i(st_o), .dev_stat_oe_i(st_oe),
        .pin_data_o(d_i), .pin_ctl_o(c_i), .pin_stat_o(st_i));

    // ************************************************************
    // Tasks
    // ************************************************************
    task summarize;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
            summarize();
        end
        q = prdata;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task wait_evt;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!(wake === 1'b1 && smi === 1'b1) && n < 16);
        check(32'(n < 16), 32'h0000_0001);
    endtask

    task owner(input logic [31:0] exp);
        apb(1'b0, OFS_OWNER, 32'h0000_0000);
        check(q & 32'h0000_0001, exp);
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        summarize();
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        {psel, penable, pwrite, port_sel, irq_in, smi_in, drq_in} = '0;
        paddr = '0; pwdata = '0; fs = 10'h2B6; media = 5'h0A; fdd_in = 5'h15;
        pin = 1'b1; rst = 1'b1; err_count = 0; checks_done = 0;
        tick(5);
        rst <= 1'b0;
        apb(1'b0, OFS_CFG, 32'h0000_0000);
        check(q, 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        check({q[30:0], pslverr}, 32'h0000_0001);
        apb(1'b1, OFS_CFG, 32'h0000_0001);
        tick(2);
        check(32'(pp_en), 32'h0000_0001);
        apb(1'b1, OFS_CFG, 32'h0000_0000);
        tick(2);
        check(32'(pp_en), 32'h0000_0000);
        $display("test power done");
        apb(1'b1, OFS_PP_DATA, 32'h0000_00A5);
        {irq_in, smi_in, drq_in} <= 3'h7;
        apb(1'b1, OFS_CFG, 32'h0000_0003);
        tick(2);
        check(32'(pp_en), 32'h0000_0000);
        check(32'({pp_irq, pp_smi, pp_drq}), 32'h0000_0000);
        check(32'(fdc_rd), 32'h0000_000A);
        check(32'(st_oe), 32'h0000_001F);
        check(32'(st_o), 32'({fs[FD_HDS], fs[FD_WGT], fs[FD_WDA], fs[FD_MT1], fs[FD_DS1]}));
        check(32'(c_oe), 32'h0000_000E);
        check(32'(c_o[3:1]), 32'({fs[FD_STP], fs[FD_DIR], fs[FD_DEN]}));
        check(32'(d_oe), 32'h0000_0000);
        apb(1'b0, OFS_PP_DATA, 32'h0000_0000);
        check(q, 32'h0000_00A5);
        apb(1'b0, OFS_PP_CTRL, 32'h0000_0000);
        check(q, 32'h0000_0004);
        apb(1'b0, OFS_PP_STAT, 32'h0000_0000);
        check(q, 32'h0000_0048);
        port_sel <= 1'b1;
        tick(2);
        check(32'(fdd_oe), 32'h0000_0000);
        port_sel <= 1'b0;
        tick(2);
        check(32'(fdd_oe), 32'h0000_03FF);
        check(32'(fdd_out), 32'(fs));
        $display("test single drive done");
        apb(1'b1, OFS_CFG, 32'h0000_0005);
        tick(2);
        check(32'(c_oe), 32'h0000_000F);
        check(32'(d_oe), 32'h0000_0040);
        check(32'({d_o[6], c_o[0]}), 32'({fs[FD_MT0], fs[FD_DS0]}));
        apb(1'b1, OFS_CFG, 32'h0000_0001);
        tick(2);
        check(32'(pp_en), 32'h0000_0001);
        check(32'({pp_irq, pp_smi, pp_drq}), 32'h0000_0007);
        check(32'(fdc_rd), 32'h0000_0015);
        check(32'({d_oe, d_o}), 32'h0000_FFA5);
        $display("test dual drive done");
        apb(1'b1, OFS_WAKE_EN, 32'h0000_0020);
        apb(1'b1, OFS_SMI_EN, 32'h0000_0010);
        apb(1'b1, OFS_INT_MASK, 32'h0000_0001);
        apb(1'b1, OFS_GPIO_CFG, 32'h0000_0009);
        apb(1'b1, OFS_CFG, 32'h0000_0013);
        owner(32'h0000_0000);
        apb(1'b1, OFS_INT_STAT, 32'h0000_0003);
        pin <= 1'b0;
        wait_evt();
        tick(3);
        check(32'(irq), 32'h0000_0001);
        owner(32'h0000_0001);
        apb(1'b1, OFS_INT_STAT, 32'h0000_0001);
        tick(2);
        check(32'(irq), 32'h0000_0000);
        apb(1'b1, OFS_GPIO_CFG, 32'h0000_000B);
        owner(32'h0000_0000);
        apb(1'b1, OFS_CFG, 32'h0000_0023);
        owner(32'h0000_0000);
        apb(1'b1, OFS_CFG, 32'h0000_0003);
        owner(32'h0000_0001);
        pin <= 1'b1;
        wait_evt();
        owner(32'h0000_0001);
        $display("test switch done");
        rst <= 1'b1;
        tick(2);
        check(32'({fdc_rd, pp_en, irq, wake}), 32'h0000_00F8);
        rst <= 1'b0;
        apb(1'b0, OFS_INT_STAT, 32'h0000_0000);
        check(q, 32'h0000_0000);
        apb(1'b0, OFS_CFG, 32'h0000_0000);
        check(q, 32'h0000_0000);
        $display("test reset done");
        summarize();
    end
endmodule
